// ---- core/rtc_i2c_calendar.sv ----
// Top of the I2C clock calendar: target port, BCD counters, RAM and stop detection
// Notes on behaviour
// - Seconds to year counters held in BCD, host readable and writable.
// - Date rolls over by month length, February gets 29 in leap years.
// - Hours count in 24-hour form or 12-hour form with afternoon flag.
// - Wave enable set: open-drain wave pin toggles at selected rate.
// - Host reads and writes are ignored while main supply is failed.
// - Counters keep advancing while host access is blocked.
// - Supply failure switches to backup automatically, no host action.
// - Stop flag sets after the oscillator has been still about 100 ms.
// - 56 bytes of host storage that survive backup operation.
// - Timebase is a 32.768 kHz crystal or external oscillator.
// - Rate 00 is 1 Hz, 01 4.096k, 10 8.192k, 11 32.768k.
// - Wave disabled: pin holds the idle level bit.
// - Stop flag stays until written 0; writing 1 leaves it.
// - Any two-digit year divisible by four is a leap year.
`include "rtc_regs.svh"
module rtc_i2c_calendar #(
    parameter logic [6:0] I2C_ADDR = 7'h30,
    parameter int STOP_CYCLES = `RTC_OSF_MS * (`RTC_CLK_HZ / 1000),
    parameter int STOP_W = 24
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic crystal_input,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_data_out,
    output logic sda_oe_out,
    output logic wave_output_pin_data_out,
    output logic wave_output_pin_oe_out,
    input wire logic vcc_low_in,
    output logic on_backup_out,
    output logic osc_stopped_flag_out
);
    import rtc_pkg::*;

    if (STOP_CYCLES < 2 || STOP_CYCLES >= (2 ** STOP_W)) begin
        $error("STOP_CYCLES does not fit the stop counter");
    end

    localparam logic [STOP_W-1:0] STOP_LAST = STOP_W'(STOP_CYCLES - 1);

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    rtc_osc_if osc_if ();

    // ------------------------------------------------------------------
    // Synchronisers for pins and the oscillator domain
    // ------------------------------------------------------------------
    logic scl_m_reg, scl_s_reg, scl_d_reg, sda_m_reg, sda_s_reg, sda_d_reg;
    logic pf_m_reg, pf_s_reg, tgl_m_reg, tgl_s_reg, tgl_d_reg;
    logic beat_m_reg, beat_s_reg, beat_d_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
            {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
            {pf_m_reg, pf_s_reg} <= 2'h0;
            {tgl_m_reg, tgl_s_reg, tgl_d_reg} <= 3'h0;
            {beat_m_reg, beat_s_reg, beat_d_reg} <= 3'h0;
        end else begin
            {scl_m_reg, scl_s_reg, scl_d_reg} <= {scl_in, scl_m_reg, scl_s_reg};
            {sda_m_reg, sda_s_reg, sda_d_reg} <= {sda_in, sda_m_reg, sda_s_reg};
            {pf_m_reg, pf_s_reg} <= {vcc_low_in, pf_m_reg};
            {tgl_m_reg, tgl_s_reg, tgl_d_reg} <= {osc_if.tick_tgl, tgl_m_reg, tgl_s_reg};
            {beat_m_reg, beat_s_reg, beat_d_reg} <= {osc_if.beat, beat_m_reg, beat_s_reg};
        end
    end

    wire scl_rise = scl_s_reg & ~scl_d_reg;
    wire scl_fall = ~scl_s_reg & scl_d_reg;
    wire bus_start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    wire bus_stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
    wire sec_tick = tgl_s_reg ^ tgl_d_reg;
    wire beat_chg = beat_s_reg ^ beat_d_reg;

    // ------------------------------------------------------------------
    // Counter and control state
    // ------------------------------------------------------------------
    logic [7:0] sec_reg, year_reg;
    logic [6:0] min_reg, hour_reg;
    logic [5:0] date_reg;
    logic [4:0] month_reg;
    logic [2:0] day_reg;
    logic level_reg, wave_en_reg, osf_reg;
    rtc_rate_t rate_reg;
    logic [7:0] ram_reg [`RTC_RAM_BYTES];
    logic [STOP_W-1:0] stop_cnt_reg;

    // ------------------------------------------------------------------
    // Carry chain, evaluated on the second tick
    // ------------------------------------------------------------------
    wire sec_wrap = sec_reg[6:0] == `RTC_SEC_MAX;
    wire min_wrap = min_reg == `RTC_MIN_MAX;
    wire c_min = sec_tick & sec_wrap;
    wire c_hour = c_min & min_wrap;
    wire [7:0] sec_bcd = bcd_inc({1'b0, sec_reg[6:0]});
    wire [6:0] sec_inc = sec_bcd[6:0];
    wire [7:0] sec_next = {sec_reg[`RTC_SEC_STOP_BIT], sec_wrap ? 7'h00 : sec_inc};
    wire [7:0] min_bcd = bcd_inc({1'b0, min_reg});
    wire [6:0] min_next = min_wrap ? 7'h00 : min_bcd[6:0];

    wire mode12 = hour_reg[`RTC_HOUR_12_BIT];
    wire pm = hour_reg[`RTC_HOUR_PM_BIT];
    wire h24_wrap = hour_reg[5:0] == `RTC_H24_MAX;
    wire h12_eleven = hour_reg[4:0] == `RTC_H12_ELEVEN;
    wire h12_noon = hour_reg[4:0] == `RTC_H12_NOON;
    wire [7:0] h24_bcd = bcd_inc({2'h0, hour_reg[5:0]});
    wire [7:0] h12_bcd = bcd_inc({3'h0, hour_reg[4:0]});
    wire [5:0] h24_inc = h24_bcd[5:0];
    wire [4:0] h12_inc = h12_bcd[4:0];
    wire [6:0] h24_next = {1'b0, h24_wrap ? 6'h00 : h24_inc};
    wire [6:0] h12_next = {1'b1, pm ^ h12_eleven, h12_noon ? `RTC_H12_ONE : h12_inc};
    wire [6:0] hour_next = mode12 ? h12_next : h24_next;
    wire c_day = c_hour & (mode12 ? (pm & h12_eleven) : h24_wrap);

    wire [2:0] day_next = (day_reg == `RTC_DAY_MAX) ? `RTC_DAY_ONE : day_reg + 3'h1;

    wire [7:0] year_bin = {1'b0, year_reg[7:4], 3'h0} + {3'h0, year_reg[7:4], 1'b0}
                          + {4'h0, year_reg[3:0]};
    wire leap = year_bin[1:0] == 2'h0;
    wire short30 = (month_reg == `RTC_APR) | (month_reg == `RTC_JUN)
                   | (month_reg == `RTC_SEP) | (month_reg == `RTC_NOV);
    wire [5:0] last_date = (month_reg == `RTC_FEB) ? (leap ? `RTC_LAST_29 : `RTC_LAST_28) :
                           short30 ? `RTC_LAST_30 : `RTC_LAST_31;
    wire date_wrap = date_reg == last_date;
    wire [7:0] date_bcd = bcd_inc({2'h0, date_reg});
    wire [5:0] date_next = date_wrap ? `RTC_DATE_ONE : date_bcd[5:0];
    wire c_month = c_day & date_wrap;
    wire month_wrap = month_reg == `RTC_MONTH_MAX;
    wire [7:0] month_bcd = bcd_inc({3'h0, month_reg});
    wire [4:0] month_next = month_wrap ? `RTC_MONTH_ONE : month_bcd[4:0];
    wire c_year = c_month & month_wrap;
    wire [7:0] year_next = (year_reg == `RTC_YEAR_MAX) ? 8'h00 : bcd_inc(year_reg);

    // ------------------------------------------------------------------
    // Target port state
    // ------------------------------------------------------------------
    rtc_i2c_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] sh_reg;
    logic [5:0] ptr_reg;
    logic rw_reg, first_reg, sda_oe_reg;

    wire byte_done = scl_fall & (bit_cnt_reg == 4'h8);
    wire addr_hit = sh_reg[7:1] == I2C_ADDR;
    wire wr_stb = (state_reg == RTC_ST_WDATA) & byte_done & ~first_reg & ~pf_s_reg;
    wire [7:0] wr_data = sh_reg;
    wire is_ram = ptr_reg >= `RTC_RAM_BASE;
    wire [5:0] ram_idx = ptr_reg - `RTC_RAM_BASE;
    wire [7:0] ctrl_byte = {level_reg, 1'b0, osf_reg, wave_en_reg, 2'h0, rate_reg};
    wire [7:0] time_byte [8];
    assign time_byte[0] = sec_reg;
    assign time_byte[1] = {1'b0, min_reg};
    assign time_byte[2] = {1'b0, hour_reg};
    assign time_byte[3] = {5'h00, day_reg};
    assign time_byte[4] = {2'h0, date_reg};
    assign time_byte[5] = {3'h0, month_reg};
    assign time_byte[6] = year_reg;
    assign time_byte[7] = ctrl_byte;
    wire [7:0] rd_byte = is_ram ? ram_reg[ram_idx] : time_byte[ptr_reg[2:0]];
    wire wr_time = wr_stb & ~is_ram;

    // ------------------------------------------------------------------
    // Counters: tick first, a host write of the same byte wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sec_reg <= 8'h00;
            min_reg <= 7'h00;
            hour_reg <= 7'h00;
            day_reg <= `RTC_DAY_ONE;
            date_reg <= `RTC_DATE_ONE;
            month_reg <= `RTC_MONTH_ONE;
            year_reg <= 8'h00;
        end else begin
            if (sec_tick) sec_reg <= sec_next;
            if (c_min) min_reg <= min_next;
            if (c_hour) hour_reg <= hour_next;
            if (c_day) day_reg <= day_next;
            if (c_day) date_reg <= date_next;
            if (c_month) month_reg <= month_next;
            if (c_year) year_reg <= year_next;
            if (wr_time && ptr_reg == `RTC_A_SEC) sec_reg <= wr_data;
            if (wr_time && ptr_reg == `RTC_A_MIN) min_reg <= wr_data[6:0];
            if (wr_time && ptr_reg == `RTC_A_HOUR) hour_reg <= wr_data[6:0];
            if (wr_time && ptr_reg == `RTC_A_DAY) day_reg <= wr_data[2:0];
            if (wr_time && ptr_reg == `RTC_A_DATE) date_reg <= wr_data[5:0];
            if (wr_time && ptr_reg == `RTC_A_MONTH) month_reg <= wr_data[4:0];
            if (wr_time && ptr_reg == `RTC_A_YEAR) year_reg <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Control byte and oscillator stop detection
    // ------------------------------------------------------------------
    wire ctrl_wr = wr_time & (ptr_reg == `RTC_A_CTRL);
    wire osf_set = stop_cnt_reg == STOP_LAST;
    wire osf_clr = ctrl_wr & ~wr_data[`RTC_CTRL_OSF_BIT];

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_reg <= `RTC_RST_LEVEL;
            wave_en_reg <= `RTC_RST_WAVE_EN;
            rate_reg <= `RTC_RST_RATE;
            osf_reg <= `RTC_RST_OSF;
            stop_cnt_reg <= '0;
        end else begin
            if (ctrl_wr) begin
                level_reg <= wr_data[`RTC_CTRL_LEVEL_BIT];
                wave_en_reg <= wr_data[`RTC_CTRL_WAVE_EN_BIT];
                rate_reg <= wr_data[`RTC_CTRL_RATE_HI:`RTC_CTRL_RATE_LO];
            end
            if (osf_set) osf_reg <= 1'b1;
            else if (osf_clr) osf_reg <= 1'b0;
            if (beat_chg) stop_cnt_reg <= '0;
            else if (!osf_set) stop_cnt_reg <= stop_cnt_reg + 1'b1;
        end
    end

    // Storage keeps its contents whatever the supply state
    always_ff @(posedge clk_in) begin
        if (wr_stb && is_ram) ram_reg[ram_idx] <= wr_data;
    end

    // ------------------------------------------------------------------
    // Target port: address, pointer, write and read bytes
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= RTC_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            ptr_reg <= 6'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (pf_s_reg || bus_stop) begin
            state_reg <= RTC_ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else if (bus_start) begin
            state_reg <= RTC_ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                RTC_ST_IDLE: begin
                end
                RTC_ST_ADDR, RTC_ST_WDATA: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_s_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done && state_reg == RTC_ST_ADDR) begin
                        state_reg <= addr_hit ? RTC_ST_ACK_A : RTC_ST_IDLE;
                        sda_oe_reg <= addr_hit;
                        rw_reg <= sh_reg[0];
                    end else if (byte_done) begin
                        state_reg <= RTC_ST_ACK_W;
                        sda_oe_reg <= 1'b1;
                        first_reg <= 1'b0;
                        ptr_reg <= first_reg ? sh_reg[5:0] : ptr_reg + 6'h01;
                    end
                end
                RTC_ST_ACK_A: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        state_reg <= rw_reg ? RTC_ST_RDATA : RTC_ST_WDATA;
                        first_reg <= ~rw_reg;
                        sh_reg <= rd_byte;
                        sda_oe_reg <= rw_reg & ~rd_byte[7];
                        if (rw_reg) ptr_reg <= ptr_reg + 6'h01;
                    end
                end
                RTC_ST_ACK_W: begin
                    if (scl_fall) begin
                        state_reg <= RTC_ST_WDATA;
                        bit_cnt_reg <= 4'h0;
                        sda_oe_reg <= 1'b0;
                    end
                end
                RTC_ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        state_reg <= RTC_ST_ACK_R;
                        sda_oe_reg <= 1'b0;
                    end else if (scl_fall) begin
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        sda_oe_reg <= ~sh_reg[6];
                    end
                end
                RTC_ST_ACK_R: begin
                    if (scl_rise && sda_s_reg) begin
                        state_reg <= RTC_ST_IDLE;
                    end else if (scl_fall) begin
                        state_reg <= RTC_ST_RDATA;
                        bit_cnt_reg <= 4'h0;
                        sh_reg <= rd_byte;
                        sda_oe_reg <= ~rd_byte[7];
                        ptr_reg <= ptr_reg + 6'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Oscillator domain and outputs
    // ------------------------------------------------------------------
    assign osc_if.osc_run = ~sec_reg[`RTC_SEC_STOP_BIT];
    assign osc_if.wave_en = wave_en_reg;
    assign osc_if.idle_level = level_reg;
    assign osc_if.rate = rate_reg;

    rtc_osc u_osc (
        .osc_clk_in(crystal_input),
        .rstn_in(rstn_in),
        .link(osc_if)
    );

    assign sda_data_out = 1'b0;
    assign sda_oe_out = sda_oe_reg;
    assign wave_output_pin_data_out = 1'b0;
    assign wave_output_pin_oe_out = osc_if.wave_low;
    assign on_backup_out = pf_s_reg;
    assign osc_stopped_flag_out = osf_reg;
endmodule

// ---- core/rtc_osc.sv ----
// Oscillator-domain divider: one-second tick, heartbeat and square-wave pin drive
`include "rtc_regs.svh"
module rtc_osc (
    input wire logic osc_clk_in,
    input wire logic rstn_in,
    rtc_osc_if.osc link
);
    import rtc_pkg::*;

    logic rst_m_reg, rst_s_reg;
    logic run_m_reg, run_s_reg, en_m_reg, en_s_reg, lvl_m_reg, lvl_s_reg;
    rtc_rate_t rate_m_reg, rate_p_reg, rate_q_reg, rate_s_reg;
    logic [`RTC_DIV_W-1:0] div_reg;
    logic tick_tgl_reg, pos_tgl_reg, neg_tgl_reg;
    logic full_rate, wave_sel, wave_level, div_wrap;

    // ------------------------------------------------------------------
    // Reset release and control synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge osc_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_m_reg <= 1'b0;
            rst_s_reg <= 1'b0;
        end else begin
            rst_m_reg <= 1'b1;
            rst_s_reg <= rst_m_reg;
        end
    end

    always_ff @(posedge osc_clk_in or negedge rst_s_reg) begin
        if (!rst_s_reg) begin
            run_m_reg <= 1'b0;
            run_s_reg <= 1'b0;
            en_m_reg <= `RTC_RST_WAVE_EN;
            en_s_reg <= `RTC_RST_WAVE_EN;
            lvl_m_reg <= `RTC_RST_LEVEL;
            lvl_s_reg <= `RTC_RST_LEVEL;
            rate_m_reg <= `RTC_RST_RATE;
            rate_p_reg <= `RTC_RST_RATE;
            rate_q_reg <= `RTC_RST_RATE;
            rate_s_reg <= `RTC_RST_RATE;
        end else begin
            run_m_reg <= link.osc_run;
            run_s_reg <= run_m_reg;
            en_m_reg <= link.wave_en;
            en_s_reg <= en_m_reg;
            lvl_m_reg <= link.idle_level;
            lvl_s_reg <= lvl_m_reg;
            rate_m_reg <= link.rate;
            rate_p_reg <= rate_m_reg;
            rate_q_reg <= rate_p_reg;
            // Two-bit word: take it only once two settled samples agree
            if (rate_p_reg == rate_q_reg) rate_s_reg <= rate_q_reg;
        end
    end

    // ------------------------------------------------------------------
    // Divide by 32768 for the second tick
    // ------------------------------------------------------------------
    assign div_wrap = &div_reg;

    always_ff @(posedge osc_clk_in or negedge rst_s_reg) begin
        if (!rst_s_reg) begin
            div_reg <= '0;
            tick_tgl_reg <= 1'b0;
            pos_tgl_reg <= 1'b0;
        end else if (run_s_reg) begin
            div_reg <= div_reg + 1'b1;
            tick_tgl_reg <= tick_tgl_reg ^ div_wrap;
            pos_tgl_reg <= ~pos_tgl_reg;
        end
    end

    // Falling-edge copy; while run_s_reg is set the pair differs for half of every oscillator cycle
    always_ff @(negedge osc_clk_in or negedge rst_s_reg) begin
        if (!rst_s_reg) begin
            neg_tgl_reg <= 1'b0;
        end else begin
            neg_tgl_reg <= pos_tgl_reg;
        end
    end

    // ------------------------------------------------------------------
    // Square wave select; seconds advance on the 1 Hz falling edge
    // ------------------------------------------------------------------
    assign full_rate = pos_tgl_reg ^ neg_tgl_reg;
    assign wave_sel = (rate_s_reg == 2'h0) ? div_reg[14] :
                      (rate_s_reg == 2'h1) ? div_reg[2] :
                      (rate_s_reg == 2'h2) ? div_reg[1] : full_rate;
    assign wave_level = en_s_reg ? wave_sel : lvl_s_reg;

    assign link.wave_low = ~wave_level;
    assign link.tick_tgl = tick_tgl_reg;
    assign link.beat = div_reg[`RTC_BEAT_BIT];
endmodule

// ---- core/rtc_osc_if.sv ----
// Signals between the calendar core and the oscillator-domain divider
interface rtc_osc_if;
    logic osc_run;
    logic wave_en;
    logic idle_level;
    rtc_pkg::rtc_rate_t rate;
    logic tick_tgl;
    logic beat;
    logic wave_low;
    modport core (output osc_run, wave_en, idle_level, rate,
                  input tick_tgl, beat, wave_low);
    modport osc (input osc_run, wave_en, idle_level, rate,
                 output tick_tgl, beat, wave_low);
endinterface

// ---- core/rtc_pkg.sv ----
// Shared types of the clock calendar
package rtc_pkg;
    typedef logic [1:0] rtc_rate_t;
    typedef enum logic [6:0] {
        RTC_ST_IDLE  = 7'h01,
        RTC_ST_ADDR  = 7'h02,
        RTC_ST_ACK_A = 7'h04,
        RTC_ST_WDATA = 7'h08,
        RTC_ST_ACK_W = 7'h10,
        RTC_ST_RDATA = 7'h20,
        RTC_ST_ACK_R = 7'h40
    } rtc_i2c_state_t;
endpackage

// ---- core/rtc_regs.svh ----
// Register map, field positions, reset values and timing constants of the clock calendar
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ----------------------------------------------------------------------
// Register pointer map (6-bit pointer)
// ----------------------------------------------------------------------
`define RTC_A_SEC 6'h00
`define RTC_A_MIN 6'h01
`define RTC_A_HOUR 6'h02
`define RTC_A_DAY 6'h03
`define RTC_A_DATE 6'h04
`define RTC_A_MONTH 6'h05
`define RTC_A_YEAR 6'h06
`define RTC_A_CTRL 6'h07
`define RTC_RAM_BASE 6'h08
`define RTC_RAM_BYTES 56

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTC_SEC_STOP_BIT 7
`define RTC_HOUR_12_BIT 6
`define RTC_HOUR_PM_BIT 5
`define RTC_CTRL_LEVEL_BIT 7
`define RTC_CTRL_OSF_BIT 5
`define RTC_CTRL_WAVE_EN_BIT 4
`define RTC_CTRL_RATE_HI 1
`define RTC_CTRL_RATE_LO 0

// ----------------------------------------------------------------------
// Reset values and calendar limits
// ----------------------------------------------------------------------
`define RTC_RST_LEVEL 1'b1
`define RTC_RST_WAVE_EN 1'b1
`define RTC_RST_RATE 2'h3
`define RTC_RST_OSF 1'b1
`define RTC_SEC_MAX 7'h59
`define RTC_MIN_MAX 7'h59
`define RTC_H24_MAX 6'h23
`define RTC_H12_ELEVEN 5'h11
`define RTC_H12_NOON 5'h12
`define RTC_H12_ONE 5'h01
`define RTC_DAY_MAX 3'h7
`define RTC_DAY_ONE 3'h1
`define RTC_DATE_ONE 6'h01
`define RTC_MONTH_MAX 5'h12
`define RTC_MONTH_ONE 5'h01
`define RTC_YEAR_MAX 8'h99
`define RTC_FEB 5'h02
`define RTC_APR 5'h04
`define RTC_JUN 5'h06
`define RTC_SEP 5'h09
`define RTC_NOV 5'h11
`define RTC_LAST_31 6'h31
`define RTC_LAST_30 6'h30
`define RTC_LAST_29 6'h29
`define RTC_LAST_28 6'h28

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTC_CLK_HZ 125000000
`define RTC_OSF_MS 100
`define RTC_OSC_HZ 32768
`define RTC_DIV_W 15
`define RTC_BEAT_BIT 3

`endif

// ---- tb/rtc_ck_properties.sv ----
// Port checker of the I2C clock calendar
module rtc_ck (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic crystal_input,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_data_out,
    input wire logic sda_oe_out,
    input wire logic wave_output_pin_data_out,
    input wire logic wave_output_pin_oe_out,
    input wire logic vcc_low_in,
    input wire logic on_backup_out,
    input wire logic osc_stopped_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_sda_open_drain: assert property (!sda_data_out)
        else $error("sda data driven high");
    a_wave_open_drain: assert property (!wave_output_pin_data_out)
        else $error("wave data driven high");
    a_backup_enter: assert property ($rose(vcc_low_in) |-> ##[1:3] on_backup_out)
        else $error("backup not entered");
    a_backup_leave: assert property ($fell(vcc_low_in) |-> ##[1:3] !on_backup_out)
        else $error("backup not left");
    a_backup_silent: assert property (on_backup_out [*2] |-> !sda_oe_out)
        else $error("sda pulled while on backup");
    a_flag_clear_cause: assert property ($fell(osc_stopped_flag_out) |->
        !scl_in && !on_backup_out) else $error("stop flag cleared without write");
    a_ack_timing: assert property ($rose(sda_oe_out) |->
        !scl_in && !$past(scl_in, 2) && $past(scl_in, 8)) else $error("sda drive mistimed");
    a_oe_stands: assert property (scl_in && $past(scl_in, 3) && !on_backup_out |->
        $stable(sda_oe_out)) else $error("sda moved while scl high");
endmodule
bind rtc_i2c_calendar rtc_ck rtc_ck_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .crystal_input(crystal_input), .scl_in(scl_in), .sda_in(sda_in),
    .sda_data_out(sda_data_out), .sda_oe_out(sda_oe_out),
    .wave_output_pin_data_out(wave_output_pin_data_out),
    .wave_output_pin_oe_out(wave_output_pin_oe_out), .vcc_low_in(vcc_low_in),
    .on_backup_out(on_backup_out), .osc_stopped_flag_out(osc_stopped_flag_out));

// ---- tb/rtc_host.sv ----
// I2C host controller model for the calendar target port
module rtc_host (
    input wire logic clk_in,
    input wire logic sda_oe_in,
    output logic scl_out,
    output logic sda_low_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 157; // SCL period 2.5 us, under 400 kHz
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Start when stop is 0, else stop; SDA moves with SCL high only here
    task automatic cond(input logic stop);
        hc(HALF);
        sda_low_out <= stop;
        hc(HALF);
        scl_out <= 1'b1;
        hc(HALF);
        sda_low_out <= ~stop;
        hc(HALF);
        if (!stop) scl_out <= 1'b0;
    endtask
    // Nine bits, MSB first; rx holds the wire level at each SCL high
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            hc(HALF / 2);
            sda_low_out <= ~tx[i];
            hc(HALF / 2);
            scl_out <= 1'b1;
            hc(HALF);
            rx[i] = ~(sda_low_out | sda_oe_in);
            scl_out <= 1'b0;
        end
    endtask
endmodule

// ---- tb/rtc_i2c_calendar_test.sv ----
// Self-checking bench of the I2C clock calendar
module rtc_i2c_calendar_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic crystal_input = 1'b0;
    logic vcc_low_in = 1'b0;
    logic scl, sda_low, sda_oe, wave_oe, on_backup, osc_stopped_flag;
    int failures = 0;
    int checks_done = 0;
    int edges = 0;
    initial forever #4 clk_in = ~clk_in;
    initial begin
        #1.7;
        forever #3 crystal_input = ~crystal_input;
    end
    always @(wave_oe) edges++;
    rtc_i2c_calendar #(.STOP_CYCLES(64)) rtc_i2c_calendar_i (.clk_in(clk_in),
        .rstn_in(rstn_in), .crystal_input(crystal_input), .scl_in(scl),
        .sda_in(~(sda_low | sda_oe)), .sda_data_out(), .sda_oe_out(sda_oe),
        .wave_output_pin_data_out(), .wave_output_pin_oe_out(wave_oe),
        .vcc_low_in(vcc_low_in), .on_backup_out(on_backup), .osc_stopped_flag_out(osc_stopped_flag));
    rtc_host rtc_host_i (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl),
        .sda_low_out(sda_low));
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp1(input string what, input logic exp, input logic got);
        cmp8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic wr(input logic [7:0] d[$], input logic ack_exp);
        logic [8:0] rx;
        logic acks;
        rtc_host_i.cond(1'b0);
        rtc_host_i.xfer({7'h30, 2'h1}, rx);
        acks = ~rx[0];
        foreach (d[i]) begin
            rtc_host_i.xfer({d[i], 1'b1}, rx);
            acks &= ~rx[0];
        end
        rtc_host_i.cond(1'b1);
        cmp1("write ack", ack_exp, acks);
    endtask
    // Byte value ee marks a byte that is read but not compared
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp[$]);
        logic [8:0] rx;
        wr('{ptr}, 1'b1);
        rtc_host_i.cond(1'b0);
        rtc_host_i.xfer({7'h30, 2'h3}, rx);
        foreach (exp[i]) begin
            rtc_host_i.xfer({8'hff, i == exp.size() - 1}, rx);
            if (exp[i] != 8'hee) cmp8("read byte", exp[i], rx[8:1]);
        end
        rtc_host_i.cond(1'b1);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (130000) @(posedge clk_in);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        cmp1("flag in reset", 1'b1, osc_stopped_flag);
        rstn_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        edges = 0;
        repeat (96) @(posedge clk_in);
        cmp1("rate 11 edges", 1'b1, edges >= 254 && edges <= 258);
        rd(8'h07, '{8'hb3});
        $display("reset test done");
        wr('{8'h07, 8'h11}, 1'b1);
        cmp1("flag cleared", 1'b0, osc_stopped_flag);
        edges = 0;
        repeat (768) @(posedge clk_in);
        cmp1("rate 01 edges", 1'b1, edges >= 254 && edges <= 258);
        $display("wave test done");
        wr('{8'h00, 8'hd9, 8'h59, 8'h71, 8'h07, 8'h28, 8'h02, 8'h04, 8'ha0}, 1'b1);
        cmp1("flag after halt", 1'b1, osc_stopped_flag);
        cmp1("idle level high", 1'b0, wave_oe);
        wr('{8'h3f, 8'h5a, 8'h59}, 1'b1);
        $display("setup test done");
        vcc_low_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        cmp1("on backup", 1'b1, on_backup);
        wr('{8'h3f, 8'ha5}, 1'b0);
        repeat (7000) @(posedge clk_in);
        vcc_low_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        cmp1("off backup", 1'b0, on_backup);
        $display("power test done");
        rd(8'h3f, '{8'h5a, 8'hee, 8'h00, 8'h52, 8'h01, 8'h29, 8'h02, 8'h04});
        $display("calendar test done");
        wrap_up();
    end
endmodule
